// [common/fbf_pkg.sv]
/*
 Shared constants and carriers for the buffer and bit-framing register block.
 Assumes an 8-bit register port with a 6-bit address, one clock, synchronous reset.
*/
`default_nettype none
package fbf_pkg;
  localparam int unsigned FBF_DEPTH      = 64;
  localparam int unsigned FBF_WIDTH      = 8;
  localparam logic [5:0]  FBF_ADDR_DATA  = 6'h09;
  localparam logic [5:0]  FBF_ADDR_LEVEL = 6'h0A;
  localparam logic [5:0]  FBF_ADDR_WMARK = 6'h0B;
  localparam logic [5:0]  FBF_ADDR_CTRL  = 6'h0C;
  localparam logic [5:0]  FBF_ADDR_FRAME = 6'h0D;
  localparam int unsigned FBF_FLUSH_BIT  = 7;
  localparam int unsigned FBF_TSTOP_BIT  = 7;
  localparam int unsigned FBF_TSTART_BIT = 6;
  localparam int unsigned FBF_SEND_BIT   = 7;
  localparam int unsigned FBF_ALIGN_LSB  = 4;
  localparam logic [5:0]  FBF_WMARK_RST  = 6'h08;
  localparam logic [7:0]  FBF_LEVEL_RST  = 8'h00;
  localparam logic [7:0]  FBF_CTRL_RST   = 8'h10;
  localparam logic [7:0]  FBF_FRAME_RST  = 8'h00;
  localparam logic [2:0]  FBF_MS_IDLE    = 3'h0;
  localparam logic [2:0]  FBF_MS_WTRIG   = 3'h1;
  localparam logic [2:0]  FBF_MS_TXWAIT  = 3'h2;
  localparam logic [2:0]  FBF_MS_TXING   = 3'h3;
  localparam logic [2:0]  FBF_MS_RXWAIT  = 3'h4;
  localparam logic [2:0]  FBF_MS_WDATA   = 3'h5;
  localparam logic [2:0]  FBF_MS_RXING   = 3'h6;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } fbf_reg_req_t;

  typedef struct packed {
    logic tx_wait_done;
    logic tx_done;
    logic rx_wait_done;
    logic rx_start;
    logic rx_done;
  } fbf_modem_ev_t;
endpackage : fbf_pkg
`default_nettype wire

// [hw/fbf_fifo.sv]
/*
 First-in first-out byte store with pointers and a fill count.
 Assumes the caller never pops and flushes in a way it cannot observe; flush wins over push and pop.
*/
`timescale 1ns/10ps
`default_nettype none
module fbf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_flush,
  input  wire logic             i_push,
  input  wire logic [WIDTH-1:0] i_push_data,
  input  wire logic             i_pop,
  output logic      [WIDTH-1:0] o_head,
  output logic      [AW:0]      o_count,
  output logic                  o_full,
  output logic                  o_overflow
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              empty  = (count_ff == '0);
  wire              push_ok = i_push && !o_full;
  wire              pop_ok  = i_pop && !empty;

  assign o_full     = (count_ff == (AW+1)'(DEPTH));
  assign o_overflow = i_push && o_full;
  assign o_head     = mem[rd_ptr_ff];
  assign o_count    = count_ff;

  always_ff @(posedge i_core_clk) begin
    if (push_ok && !i_flush) begin
      mem[wr_ptr_ff] <= i_push_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || i_flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push_ok);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop_ok);
      count_ff  <= count_ff + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
    end
  end
endmodule : fbf_fifo
`default_nettype wire

// [hw/fbf_modem.sv]
/*
 Transmit and receive sequencing that drives the modem state indicator.
 Assumes the transmitter and receiver report their phase ends as one-cycle events.
*/
`timescale 1ns/10ps
`default_nettype none
module fbf_modem
  import fbf_pkg::*;
(
  input  wire logic          i_core_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_transceive_active,
  input  wire logic          i_trigger,
  input  wire fbf_modem_ev_t i_ev,
  output logic [2:0]         o_state_code
);
  typedef enum logic [2:0] {S_IDLE, S_WTRIG, S_TXWAIT, S_TXING, S_RXWAIT, S_WDATA, S_RXING} fbf_ms_t;
  fbf_ms_t state_ff;
  fbf_ms_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:   if (i_transceive_active) nxt_state = S_WTRIG;
      S_WTRIG:  if (i_trigger) nxt_state = S_TXWAIT;
      S_TXWAIT: if (i_ev.tx_wait_done) nxt_state = S_TXING;
      S_TXING:  if (i_ev.tx_done) nxt_state = S_RXWAIT;
      S_RXWAIT: if (i_ev.rx_wait_done) nxt_state = S_WDATA;
      S_WDATA:  if (i_ev.rx_start) nxt_state = S_RXING;
      S_RXING:  if (i_ev.rx_done) nxt_state = S_WTRIG;
      default:  nxt_state = S_IDLE;
    endcase
    if (!i_transceive_active) begin
      nxt_state = S_IDLE;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    case (state_ff)
      S_WTRIG:  o_state_code = FBF_MS_WTRIG; // see [RULE16]
      S_TXWAIT: o_state_code = FBF_MS_TXWAIT;
      S_TXING:  o_state_code = FBF_MS_TXING;
      S_RXWAIT: o_state_code = FBF_MS_RXWAIT;
      S_WDATA:  o_state_code = FBF_MS_WDATA;
      S_RXING:  o_state_code = FBF_MS_RXING;
      default:  o_state_code = FBF_MS_IDLE;
    endcase
  end
endmodule : fbf_modem
`default_nettype wire

// [hw/fbf_regs.sv]
/*
 Buffer data port, fill level, watermark, miscellaneous control and bit-framing registers.
 Assumes a same-clock register port (one access per cycle) and same-clock transmitter,
 receiver, timer and command logic around it.
*/
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [RULE1] Data port pushes and pops a 64-byte store.
// [RULE2] Store also feeds transmitter and receiver streams.
// [RULE3] Level bits 6..0 show stored byte count.
// [RULE4] Level bit 7 write flushes pointers, overflow.
// [RULE5] Flush bit always reads back zero.
// [RULE6] Watermark bits 5..0 read/write, reset 08h.
// [RULE7] High alert when free space <= watermark.
// [RULE8] Low alert when stored bytes <= watermark.
// [RULE9] Control bits 7/6 stop/start timer, start reads 0.
// [RULE10] Control bits 2..0 show last byte valid bits.
// [RULE11] Framing bit 7 starts sending, transceive only.
// [RULE12] Receive alignment places first received bit.
// [RULE13] Host keeps alignment zero outside bitwise anticollision.
// [RULE14] Framing bits 2..0 give final byte bits.
// [RULE15] Level 00h, control 10h, framing 00h after reset.
// [RULE16] Waiting for trigger shows modem code 001.
// [RULE17] Write when full is dropped, sets overflow.
module fbf_regs
  import fbf_pkg::*;
#(
  parameter int unsigned DEPTH = FBF_DEPTH
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_nrst,
  input  wire fbf_reg_req_t  i_reg_req,
  output logic [7:0]         o_reg_rdata,
  input  wire logic          i_rx_push,
  input  wire logic [7:0]    i_rx_data,
  input  wire logic          i_rx_last_valid,
  input  wire logic [2:0]    i_rx_last_bits,
  input  wire logic          i_tx_pop,
  output logic [7:0]         o_tx_data,
  output logic               o_tx_avail,
  input  wire logic          i_transceive_active,
  input  wire fbf_modem_ev_t i_modem_ev,
  output logic [6:0]         o_fill_count,
  output logic               o_high_alert_flag,
  output logic               o_low_alert_flag,
  output logic               o_overflow_error,
  output logic               o_timer_start_strobe,
  output logic               o_timer_stop_strobe,
  output logic               o_transmit_trigger,
  output logic [2:0]         o_rx_bit_alignment,
  output logic [7:0]         o_rx_first_mask,
  output logic [2:0]         o_tx_final_bit_count,
  output logic [2:0]         o_modem_state_indicator
);
  localparam int unsigned AW = $clog2(DEPTH);

  // Mask of the bit positions that the first received bit and its successors fill in the first byte.
  function automatic logic [7:0] first_byte_mask(input logic [2:0] align);
    first_byte_mask = 8'hFF << align;
  endfunction : first_byte_mask

  function automatic logic hit(input fbf_reg_req_t req, input logic [5:0] addr);
    hit = (req.addr == addr);
  endfunction : hit

  logic [5:0]    wmark_ff;
  logic [2:0]    rx_align_ff;
  logic [2:0]    tx_last_ff;
  logic [2:0]    rx_last_ff;
  logic          ovf_ff;
  logic          tstart_ff;
  logic          tstop_ff;
  logic          send_ff;
  logic [7:0]    rdata_ff;
  logic [7:0]    nxt_rdata;
  logic [7:0]    fifo_head;
  logic [AW:0]   fifo_count;
  logic          fifo_full;
  logic          fifo_ovf;
  logic [2:0]    ms_code;

  // Register decode.
  wire wr_data  = i_reg_req.wr && hit(i_reg_req, FBF_ADDR_DATA);
  wire rd_data  = i_reg_req.rd && hit(i_reg_req, FBF_ADDR_DATA);
  wire wr_level = i_reg_req.wr && hit(i_reg_req, FBF_ADDR_LEVEL);
  wire wr_wmark = i_reg_req.wr && hit(i_reg_req, FBF_ADDR_WMARK);
  wire wr_ctrl  = i_reg_req.wr && hit(i_reg_req, FBF_ADDR_CTRL);
  wire wr_frame = i_reg_req.wr && hit(i_reg_req, FBF_ADDR_FRAME);

  wire flush      = wr_level && i_reg_req.wdata[FBF_FLUSH_BIT]; // see [RULE4]
  wire tstart_req = wr_ctrl && i_reg_req.wdata[FBF_TSTART_BIT]; // see [RULE9]
  wire tstop_req  = wr_ctrl && i_reg_req.wdata[FBF_TSTOP_BIT]; // see [RULE9]
  // The trigger is ignored unless the transceive command is running.
  wire send_req   = wr_frame && i_reg_req.wdata[FBF_SEND_BIT] && i_transceive_active; // see [RULE11]

  // Host and stream sides share one push and one pop path; the host write takes the data lane,
  // so a receiver byte in the same cycle is lost. Software must not touch the data port mid-frame.
  wire       push      = wr_data || i_rx_push; // see [RULE2]
  wire [7:0] push_data = wr_data ? i_reg_req.wdata : i_rx_data;
  wire       pop       = rd_data || i_tx_pop; // see [RULE2]

  fbf_fifo #(
    .WIDTH (FBF_WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_nrst      (i_nrst),
    .i_flush     (flush),
    .i_push      (push),
    .i_push_data (push_data),
    .i_pop       (pop),
    .o_head      (fifo_head),
    .o_count     (fifo_count),
    .o_full      (fifo_full),
    .o_overflow  (fifo_ovf)
  ); // see [RULE1]

  fbf_modem u_modem (
    .i_core_clk          (i_core_clk),
    .i_nrst              (i_nrst),
    .i_transceive_active (i_transceive_active),
    .i_trigger           (send_req),
    .i_ev                (i_modem_ev),
    .o_state_code        (ms_code)
  );

  // Status and stream outputs.
  wire [AW:0] free_space = (AW+1)'(DEPTH) - fifo_count;
  assign o_fill_count            = 7'(fifo_count); // see [RULE3]
  assign o_high_alert_flag       = (free_space <= (AW+1)'(wmark_ff)); // see [RULE7]
  assign o_low_alert_flag        = (fifo_count <= (AW+1)'(wmark_ff)); // see [RULE8]
  assign o_overflow_error        = ovf_ff;
  assign o_tx_data               = fifo_head;
  assign o_tx_avail              = (fifo_count != '0);
  assign o_timer_start_strobe    = tstart_ff;
  assign o_timer_stop_strobe     = tstop_ff;
  assign o_transmit_trigger      = send_ff;
  assign o_rx_bit_alignment      = rx_align_ff;
  assign o_rx_first_mask         = first_byte_mask(rx_align_ff); // see [RULE12]
  assign o_tx_final_bit_count    = tx_last_ff; // see [RULE14]
  assign o_modem_state_indicator = ms_code;
  assign o_reg_rdata             = rdata_ff;

  // Read mux; write-only strobe bits and reserved bits read as zero, bit 4 of control reads its reset 1.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        FBF_ADDR_DATA:  nxt_rdata = fifo_head;
        FBF_ADDR_LEVEL: nxt_rdata = {1'b0, o_fill_count}; // see [RULE5]
        FBF_ADDR_WMARK: nxt_rdata = {2'b00, wmark_ff};
        FBF_ADDR_CTRL:  nxt_rdata = FBF_CTRL_RST | {5'h00, rx_last_ff}; // see [RULE10]
        FBF_ADDR_FRAME: nxt_rdata = {1'b0, rx_align_ff, 1'b0, tx_last_ff};
        default:        nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Configuration registers.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      wmark_ff    <= FBF_WMARK_RST; // see [RULE6]
      rx_align_ff <= FBF_FRAME_RST[6:4]; // see [RULE15]
      tx_last_ff  <= FBF_FRAME_RST[2:0];
    end else begin
      if (wr_wmark) begin
        wmark_ff <= i_reg_req.wdata[5:0]; // see [RULE6]
      end
      if (wr_frame) begin
        rx_align_ff <= i_reg_req.wdata[FBF_ALIGN_LSB +: 3]; // see [RULE12]
        tx_last_ff  <= i_reg_req.wdata[2:0]; // see [RULE14]
      end
    end
  end

  // Last-byte valid bit count, captured when the receiver closes a frame.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rx_last_ff <= FBF_CTRL_RST[2:0]; // see [RULE15]
    end else if (i_rx_last_valid) begin
      rx_last_ff <= i_rx_last_bits; // see [RULE10]
    end
  end

  // The overflow event wins over a flush in the same cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ovf_ff <= 1'b0;
    end else begin
      ovf_ff <= fifo_ovf || (ovf_ff && !flush); // see [RULE17]
    end
  end

  // One-cycle strobes to the timer and transmitter.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      tstart_ff <= 1'b0;
      tstop_ff  <= 1'b0;
      send_ff   <= 1'b0;
    end else begin
      tstart_ff <= tstart_req; // see [RULE9]
      tstop_ff  <= tstop_req; // see [RULE9]
      send_ff   <= send_req; // see [RULE11]
    end
  end

  // Checks.
  property p_count_up;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (wr_data && !fifo_full && !pop && !flush) |=>
        (o_fill_count == $past(o_fill_count) + 7'h01);
  endproperty
  a_count_up: assert property (p_count_up) else $error("fill count did not rise on write"); // see [RULE3]

  property p_count_down;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (rd_data && !i_rx_push && (o_fill_count != 7'h00) && !flush) |=>
        (o_fill_count == $past(o_fill_count) - 7'h01);
  endproperty
  a_count_down: assert property (p_count_down) else $error("fill count did not fall on read"); // see [RULE3]

  property p_flush;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (flush && !fifo_ovf) |=> (o_fill_count == 7'h00) && !o_overflow_error;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left data or overflow"); // see [RULE4]

  property p_flush_reads_zero;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (i_reg_req.rd && hit(i_reg_req, FBF_ADDR_LEVEL)) |=> (o_reg_rdata[7] == 1'b0) &&
        (o_reg_rdata[6:0] == $past(o_fill_count));
  endproperty
  a_flush_reads_zero: assert property (p_flush_reads_zero) else $error("level read wrong"); // see [RULE5]

  property p_wmark_rw;
    @(posedge i_core_clk) disable iff (!i_nrst)
      wr_wmark ##1 !wr_wmark ##1 (i_reg_req.rd && hit(i_reg_req, FBF_ADDR_WMARK)) |=>
        (o_reg_rdata == {2'b00, $past(i_reg_req.wdata[5:0], 3)});
  endproperty
  a_wmark_rw: assert property (p_wmark_rw) else $error("watermark readback wrong"); // see [RULE6]

  property p_high_alert;
    @(posedge i_core_clk) disable iff (!i_nrst)
      fifo_full |-> o_high_alert_flag ##0 (o_fill_count == 7'h40);
  endproperty
  a_high_alert: assert property (p_high_alert) else $error("high alert missing when full"); // see [RULE7]

  property p_low_alert;
    @(posedge i_core_clk) disable iff (!i_nrst)
      o_low_alert_flag |-> ({1'b0, wmark_ff} >= o_fill_count) && !(o_tx_avail && wmark_ff == 6'h00);
  endproperty
  a_low_alert: assert property (p_low_alert) else $error("low alert inconsistent"); // see [RULE8]

  property p_timer_start;
    @(posedge i_core_clk) disable iff (!i_nrst)
      $rose(tstart_req) |=> o_timer_start_strobe ##1 (o_timer_start_strobe == $past(tstart_req));
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer start strobe wrong"); // see [RULE9]

  property p_rx_last;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (i_rx_last_valid ##1 !i_rx_last_valid ##1
        (i_reg_req.rd && hit(i_reg_req, FBF_ADDR_CTRL) && !i_rx_last_valid)) |=>
        (o_reg_rdata[2:0] == $past(i_rx_last_bits, 3)) && (o_reg_rdata[7:3] == 5'b00010);
  endproperty
  a_rx_last: assert property (p_rx_last) else $error("last bits readback wrong"); // see [RULE10]

  property p_trigger;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (send_req && ms_code == FBF_MS_WTRIG) |=>
        (o_modem_state_indicator == FBF_MS_TXWAIT) && o_transmit_trigger;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger did not advance modem"); // see [RULE16]

  property p_no_trigger;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (wr_frame && !i_transceive_active) |=> !o_transmit_trigger;
  endproperty
  a_no_trigger: assert property (p_no_trigger) else $error("trigger outside transceive"); // see [RULE11]

  property p_overflow;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (wr_data && fifo_full && !pop && !flush) |=>
        o_overflow_error && (o_fill_count == 7'h40);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow write not handled"); // see [RULE17]

  property p_reset_vals;
    @(posedge i_core_clk) !i_nrst |=> (wmark_ff == FBF_WMARK_RST) && (o_fill_count == 7'h00) &&
      (rx_align_ff == 3'h0) && (tx_last_ff == 3'h0) && (rx_last_ff == 3'h0);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // see [RULE15]

  property p_timer_stop;
    @(posedge i_core_clk) disable iff (!i_nrst)
      tstop_req |=> o_timer_stop_strobe;
  endproperty
  a_timer_stop: assert property (p_timer_stop) else $error("timer stop strobe missing"); // see [RULE9]

  property p_modem_wait;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (i_transceive_active && ms_code == FBF_MS_IDLE) |=>
        (o_modem_state_indicator == FBF_MS_WTRIG);
  endproperty
  a_modem_wait: assert property (p_modem_wait) else $error("modem did not wait for trigger"); // see [RULE16]

  property p_modem_idle;
    @(posedge i_core_clk) disable iff (!i_nrst)
      !i_transceive_active |=> (o_modem_state_indicator == FBF_MS_IDLE);
  endproperty
  a_modem_idle: assert property (p_modem_idle) else $error("modem not idle"); // see [RULE16]

  property p_frame_rw;
    @(posedge i_core_clk) disable iff (!i_nrst)
      wr_frame |=>
        (o_rx_bit_alignment == $past(i_reg_req.wdata[6:4])) &&
        (o_tx_final_bit_count == $past(i_reg_req.wdata[2:0]));
  endproperty
  a_frame_rw: assert property (p_frame_rw) else $error("framing fields not taken"); // see [RULE12]

  property p_data_read;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (rd_data && o_tx_avail) |=> (o_reg_rdata == $past(o_tx_data));
  endproperty
  a_data_read: assert property (p_data_read) else $error("data port read not head"); // see [RULE1]

  // Host reads and stream pops share one pop path, so the stream pop is checked on its own.
  property p_stream_pop;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (i_tx_pop && !rd_data && !push && !flush && o_tx_avail) |=>
        (o_fill_count == $past(o_fill_count) - 7'h01);
  endproperty
  a_stream_pop: assert property (p_stream_pop) else $error("stream pop did not consume"); // see [RULE2]
endmodule : fbf_regs
`default_nettype wire

// [testbench/fbf_far_model.sv]
/*
 Behavioural receiver, transmitter and modem sequencer facing the buffer block.
 Assumes the bench calls one task at a time; every output changes just after a core clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module fbf_far_model
  import fbf_pkg::*;
(
  input  wire logic     i_core_clk,
  output logic          o_rx_push,
  output logic [7:0]    o_rx_data,
  output logic          o_rx_last_valid,
  output logic [2:0]    o_rx_last_bits,
  output logic          o_tx_pop,
  output fbf_modem_ev_t o_modem_ev
);
  // Idle data lines show the inverse of the last value, so a stale byte is never mistaken for a fresh one.
  initial begin
    o_rx_push = 1'b0;
    o_rx_data = 8'h00;
    o_rx_last_valid = 1'b0;
    o_rx_last_bits = 3'h0;
    o_tx_pop = 1'b0;
    o_modem_ev = '0;
  end

  task automatic rx_byte(input logic [7:0] d);
    @(posedge i_core_clk);
    o_rx_push <= 1'b1;
    o_rx_data <= d;
    @(posedge i_core_clk);
    o_rx_push <= 1'b0;
    o_rx_data <= ~d;
    #1;
  endtask : rx_byte

  task automatic tx_take();
    @(posedge i_core_clk);
    o_tx_pop <= 1'b1;
    @(posedge i_core_clk);
    o_tx_pop <= 1'b0;
    #1;
  endtask : tx_take

  task automatic rx_last(input logic [2:0] b);
    @(posedge i_core_clk);
    o_rx_last_valid <= 1'b1;
    o_rx_last_bits <= b;
    @(posedge i_core_clk);
    o_rx_last_valid <= 1'b0;
    o_rx_last_bits <= ~b;
    #1;
  endtask : rx_last

  task automatic pulse_ev(input logic [4:0] e);
    @(posedge i_core_clk);
    o_modem_ev <= e;
    @(posedge i_core_clk);
    o_modem_ev <= '0;
    #1;
  endtask : pulse_ev
endmodule : fbf_far_model
`default_nettype wire

// [testbench/testbench.sv]
/*
 Self-checking bench for the buffer and bit-framing registers with a model queue of the store.
 Assumes the far-side model in fbf_far_model and read data registered one cycle after the request.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fbf_pkg::*;
  logic          i_core_clk;
  logic          i_nrst;
  logic          transceive;
  fbf_reg_req_t  req;
  fbf_modem_ev_t ev;
  logic [7:0]    rdata, tx_data, first_mask, rx_data, d, r;
  logic [6:0]    fill;
  logic [2:0]    align, txlast, modem, last_bits;
  logic          tx_avail, hi, lo, ovf, tstart, tstop, trig, rx_push, rx_last_valid, tx_pop;
  logic [5:0]    wm;
  logic [7:0]    model_q[$];
  int            mismatches;
  int            comparisons;

  always #20 i_core_clk = ~i_core_clk;

  fbf_regs #(.DEPTH(FBF_DEPTH)) DUT (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_req(req), .o_reg_rdata(rdata),
    .i_rx_push(rx_push), .i_rx_data(rx_data), .i_rx_last_valid(rx_last_valid),
    .i_rx_last_bits(last_bits), .i_tx_pop(tx_pop), .o_tx_data(tx_data), .o_tx_avail(tx_avail),
    .i_transceive_active(transceive), .i_modem_ev(ev), .o_fill_count(fill),
    .o_high_alert_flag(hi), .o_low_alert_flag(lo), .o_overflow_error(ovf),
    .o_timer_start_strobe(tstart), .o_timer_stop_strobe(tstop), .o_transmit_trigger(trig),
    .o_rx_bit_alignment(align), .o_rx_first_mask(first_mask), .o_tx_final_bit_count(txlast),
    .o_modem_state_indicator(modem));

  fbf_far_model far (
    .i_core_clk(i_core_clk), .o_rx_push(rx_push), .o_rx_data(rx_data), .o_rx_last_valid(rx_last_valid),
    .o_rx_last_bits(last_bits), .o_tx_pop(tx_pop), .o_modem_ev(ev));

  function automatic logic exp_high(input int n, input logic [5:0] w);
    return (FBF_DEPTH - n) <= w;
  endfunction : exp_high

  function automatic logic exp_low(input int n, input logic [5:0] w);
    return n <= w;
  endfunction : exp_low

  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : chk_bit

  task automatic chk_state(input logic exp_ovf);
    int n;
    n = model_q.size();
    chk_byte({1'b0, fill}, 8'(n), "fill count");
    chk_bit(hi, exp_high(n, wm), "high alert");
    chk_bit(lo, exp_low(n, wm), "low alert");
    chk_bit(ovf, exp_ovf, "overflow");
    chk_bit(tx_avail, n != 0, "stream available");
  endtask : chk_state

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_core_clk);
    req <= '0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge i_core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_core_clk);
    req <= '0;
    #1;
    v = rdata;
  endtask : reg_rd

  task automatic reset_sweep();
    logic [5:0] a [5];
    logic [7:0] e [5];
    logic [7:0] v;
    a = '{FBF_ADDR_LEVEL, FBF_ADDR_WMARK, FBF_ADDR_CTRL, FBF_ADDR_FRAME, 6'h3F};
    e = '{FBF_LEVEL_RST, {2'b00, FBF_WMARK_RST}, FBF_CTRL_RST, FBF_FRAME_RST, 8'h00};
    for (int i = 0; i < 5; i++) begin
      reg_rd(a[i], v);
      chk_byte(v, e[i], "reset value");
    end
  endtask : reset_sweep

  initial begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    i_core_clk = 1'b0;
    i_nrst = 1'b0;
    transceive = 1'b0;
    req = '0;
    mismatches = 0;
    comparisons = 0;
    wm = FBF_WMARK_RST;
    void'($urandom(45529));
    repeat (4) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    reset_sweep();
    chk_state(1'b0);
    reg_wr(6'h3F, 8'($urandom));
    reset_sweep();
    wm = 6'($urandom_range(1, 62));
    reg_wr(FBF_ADDR_WMARK, {2'b11, wm});
    reg_rd(FBF_ADDR_WMARK, d);
    chk_byte(d, {2'b00, wm}, "watermark");
    for (int i = 0; i < FBF_DEPTH; i++) begin
      d = 8'($urandom);
      reg_wr(FBF_ADDR_DATA, d);
      model_q.push_back(d);
      chk_state(1'b0);
    end
    reg_wr(FBF_ADDR_DATA, 8'hA5);
    chk_state(1'b1);
    reg_rd(FBF_ADDR_LEVEL, d);
    chk_byte(d, 8'h40, "level read");
    // Host pops, transmitter pops and receiver pushes are mixed; pushes only while there is room.
    for (int i = 0; i < 40; i++) begin
      case ($urandom_range(0, 2))
        0: begin
          reg_rd(FBF_ADDR_DATA, d);
          chk_byte(d, model_q.pop_front(), "data port read");
        end
        1: begin
          chk_byte(tx_data, model_q.pop_front(), "stream head");
          far.tx_take();
        end
        default: begin
          d = 8'($urandom);
          if (model_q.size() < FBF_DEPTH) begin
            far.rx_byte(d);
            model_q.push_back(d);
          end
        end
      endcase
      chk_state(1'b1);
    end
    reg_wr(FBF_ADDR_LEVEL, 8'h80);
    model_q.delete();
    chk_state(1'b0);
    reg_rd(FBF_ADDR_DATA, d);
    chk_state(1'b0);
    reg_wr(FBF_ADDR_DATA, 8'h3C);
    model_q.push_back(8'h3C);
    for (int k = 0; k < 2; k++) begin
      wm = (k == 0) ? 6'h00 : 6'h3F;
      reg_wr(FBF_ADDR_WMARK, {2'b00, wm});
      chk_state(1'b0);
    end
    reg_wr(FBF_ADDR_CTRL, 8'h40);
    chk_bit(tstart, 1'b1, "start strobe");
    chk_bit(tstop, 1'b0, "stop strobe idle");
    @(posedge i_core_clk);
    #1;
    chk_bit(tstart, 1'b0, "start strobe length");
    reg_wr(FBF_ADDR_CTRL, 8'h80);
    chk_bit(tstop, 1'b1, "stop strobe");
    for (int b = 0; b < 8; b++) begin
      far.rx_last(3'(b));
      reg_rd(FBF_ADDR_CTRL, d);
      chk_byte(d, FBF_CTRL_RST | 8'(b), "control read");
    end
    for (int a = 0; a < 8; a++) begin
      d = {1'b0, 3'(a), 1'b1, 3'($urandom)};
      reg_wr(FBF_ADDR_FRAME, d);
      reg_rd(FBF_ADDR_FRAME, r);
      chk_byte(r, d & 8'h77, "framing read");
      chk_byte({5'h00, align}, 8'(a), "alignment");
      chk_byte(first_mask, 8'hFF << a, "first byte mask");
      chk_byte({5'h00, txlast}, {5'h00, d[2:0]}, "final bit count");
    end
    reg_wr(FBF_ADDR_FRAME, 8'h00);
    reg_wr(FBF_ADDR_FRAME, 8'h80);
    chk_bit(trig, 1'b0, "trigger without transceive");
    chk_byte({5'h00, modem}, 8'h00, "modem idle");
    @(posedge i_core_clk);
    transceive <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk_byte({5'h00, modem}, {5'h00, FBF_MS_WTRIG}, "modem waits");
    reg_wr(FBF_ADDR_FRAME, 8'h80);
    chk_bit(trig, 1'b1, "trigger");
    chk_byte({5'h00, modem}, {5'h00, FBF_MS_TXWAIT}, "modem after trigger");
    for (int k = 0; k < 5; k++) begin
      far.pulse_ev(5'(5'h10 >> k));
      chk_byte({5'h00, modem}, (k < 4) ? 8'(3 + k) : 8'h01, "modem step");
    end
    @(posedge i_core_clk);
    transceive <= 1'b0;
    @(posedge i_core_clk);
    #1;
    chk_byte({5'h00, modem}, 8'h00, "modem back to idle");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
